// ---- common/atb_pkg.sv ----
// Shared constants and carriers for the timer time base.
// Assumes a single synchronous clock domain and an Avalon-MM register slave.
package atb_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL    = 5'h00;
  localparam logic [4:0] ADDR_EVGEN   = 5'h04;
  localparam logic [4:0] ADDR_STATUS  = 5'h08;
  localparam logic [4:0] ADDR_SLAVE   = 5'h0C;
  localparam logic [4:0] ADDR_COUNT   = 5'h10;
  localparam logic [4:0] ADDR_PRESC   = 5'h14;
  localparam logic [4:0] ADDR_PERIOD  = 5'h18;
  localparam logic [4:0] ADDR_REPEAT  = 5'h1C;

  // ----------------------------------------------------------------
  // Field positions in the control, event-generation and slave-control registers
  // ----------------------------------------------------------------
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_UPDATE_DISABLE  = 1;
  localparam int CTRL_URS   = 2;
  localparam int CTRL_DIR   = 4;
  localparam int CTRL_CMS_L = 5;
  localparam int CTRL_APRE  = 7;
  localparam int CTRL_UIE   = 8;
  localparam int EVGEN_UG   = 0;
  localparam int SLV_MODE_L = 0;
  localparam int SLV_ECLK   = 3;
  localparam int SLV_SRC_L  = 4;

  // ----------------------------------------------------------------
  // Reset values and fixed figures
  // ----------------------------------------------------------------
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [7:0]  REPEAT_RESET = 8'h00;
  localparam logic [2:0]  SLAVE_NORMAL = 3'h0;

  typedef enum logic [1:0] {ATB_SRC_MASTER, ATB_SRC_TIMER_IN, ATB_SRC_EXT_TRIG, ATB_SRC_INT_TRIG} atb_clk_src_t;

  typedef struct packed {
    logic        run;
    logic        updateDisable;
    logic        updateReqSource;
    logic        dirDown;
    logic [1:0]  centerAlign;
    logic        periodPreload;
    logic        updateIrqEn;
  } atb_ctrl_t;

  typedef struct packed {
    logic        overflow;
    logic        underflow;
    logic        updateEvent;
  } atb_events_t;

endpackage : atb_pkg

// ---- hw/atb_time_base.sv ----
// Time base of an advanced 16-bit timer: prescaler, counter, period shadow, repetition counter.
// Assumes an Avalon-MM master on clk_sys and external tick sources already synchronous to clk_sys.
module atb_time_base #(
  parameter int REP_W = 8
) (
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic [4:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic                timerInputTick,
  input  wire logic                extTriggerTick,
  input  wire logic                internalTriggerTick,
  input  wire logic                triggerUpdate,
  output atb_pkg::atb_events_t     events,
  output logic                     countEnable,
  output logic      [15:0]         counterValue,
  output logic                     updateIrq
);
  import atb_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  atb_ctrl_t   ctrl;
  logic [6:0]  slaveCtrl;
  logic [15:0] presPreload;
  logic [15:0] presShadow;
  logic [15:0] presCount;
  logic [15:0] periodPreload;
  logic [15:0] periodShadow;
  logic [15:0] next_periodShadow;
  logic [REP_W-1:0] repeatReg;
  logic [REP_W-1:0] repeatCount;
  logic        updateFlag;
  logic        ackPending;
  logic        swUpdate;
  logic        cntWrite;
  logic [15:0] cntWriteData;

  logic        wrCycle;
  logic        rdCycle;
  logic        tick;
  logic        psDone;
  logic        cntTick;
  logic        ovf;
  logic        unf;
  logic        forcedUpdate;
  logic        repZero;
  logic        updateEv;
  logic        setFlag;
  logic        centered;
  logic        normalMode;
  atb_clk_src_t clkSrc;

  // One wait state on every access, so waitrequest is low only in the second cycle.
  assign avs_waitrequest = (avs_read | avs_write) & ~ackPending;
  assign wrCycle = avs_write & ackPending;
  // Read data loads in the first cycle of a read, so it stands when waitrequest drops.
  assign rdCycle = avs_read & ~ackPending;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ackPending <= 1'b0;
    else
      ackPending <= (avs_read | avs_write) & ~ackPending;
  end

  // ----------------------------------------------------------------
  // Control and configuration writes
  // ----------------------------------------------------------------
  assign centered   = (ctrl.centerAlign != 2'h0);
  assign normalMode = (slaveCtrl[SLV_MODE_L +: 3] == SLAVE_NORMAL) & ~slaveCtrl[SLV_ECLK];

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ctrl        <= '0;
      slaveCtrl   <= '0;
      presPreload <= ZERO16;
      periodPreload <= PERIOD_RESET;
      repeatReg   <= '0;
    end
    else if (wrCycle && avs_byteenable[0])
    begin
      case (avs_address)
        ADDR_CTRL:
        begin
          ctrl.run             <= avs_writedata[CTRL_RUN];
          ctrl.updateDisable   <= avs_writedata[CTRL_UPDATE_DISABLE];
          ctrl.updateReqSource <= avs_writedata[CTRL_URS];
          ctrl.centerAlign     <= avs_writedata[CTRL_CMS_L +: 2];
          ctrl.periodPreload   <= avs_writedata[CTRL_APRE];
          ctrl.updateIrqEn     <= avs_writedata[CTRL_UIE];
          if (!centered)
            ctrl.dirDown <= avs_writedata[CTRL_DIR];
        end
        ADDR_SLAVE:  slaveCtrl <= avs_writedata[6:0];
        ADDR_PRESC:  presPreload <= avs_writedata[15:0];
        ADDR_PERIOD: periodPreload <= avs_writedata[15:0];
        ADDR_REPEAT: repeatReg <= avs_writedata[REP_W-1:0];
        default:     ;
      endcase
    end
    // Direction tracking stands apart from the write chain, so only a counter write, which takes priority here, can swallow a turn.
    if (!sys_rst && centered)
    begin
      if (cntWrite)
      begin
        if (cntWriteData == ZERO16)
          ctrl.dirDown <= 1'b0;
        else if (cntWriteData == periodShadow)
          ctrl.dirDown <= 1'b1;
      end
      else if (ovf)
        ctrl.dirDown <= 1'b1;
      else if (unf)
        ctrl.dirDown <= 1'b0;
    end
  end

  // Software-generated update and counter writes are one-cycle strobes.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      swUpdate     <= 1'b0;
      cntWrite     <= 1'b0;
      cntWriteData <= ZERO16;
    end
    else
    begin
      swUpdate     <= wrCycle && avs_byteenable[0] && avs_address == ADDR_EVGEN && avs_writedata[EVGEN_UG];
      cntWrite     <= wrCycle && avs_byteenable[0] && avs_address == ADDR_COUNT;
      cntWriteData <= avs_writedata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign clkSrc = atb_clk_src_t'(slaveCtrl[SLV_SRC_L +: 2]);

  always_comb
  begin
    case (clkSrc)
      ATB_SRC_MASTER:   tick = 1'b1;
      ATB_SRC_TIMER_IN: tick = timerInputTick;
      ATB_SRC_EXT_TRIG: tick = extTriggerTick;
      ATB_SRC_INT_TRIG: tick = internalTriggerTick;
      default:          tick = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      countEnable <= 1'b0;
    else
      countEnable <= ctrl.run;
  end

  assign forcedUpdate = swUpdate | triggerUpdate;
  assign psDone  = (presCount == presShadow);
  assign cntTick = countEnable & tick & psDone & ~forcedUpdate;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      presCount <= ZERO16;
    else if (forcedUpdate)
      presCount <= ZERO16;
    else if (countEnable && tick)
      presCount <= psDone ? ZERO16 : presCount + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Counter and update generation
  // ----------------------------------------------------------------
  assign ovf = cntTick & (centered ? (~ctrl.dirDown & counterValue == periodShadow - 16'h0001)
                                   : (~ctrl.dirDown & counterValue == periodShadow));
  assign unf = cntTick & ctrl.dirDown & (counterValue == ZERO16 || (centered && counterValue == 16'h0001));
  assign repZero  = (repeatCount == '0);
  assign updateEv = ~ctrl.updateDisable & (forcedUpdate | ((ovf | unf) & repZero));
  assign setFlag  = updateEv & ~(swUpdate & ctrl.updateReqSource);
  assign next_periodShadow = (!ctrl.periodPreload || updateEv) ? periodPreload : periodShadow;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      counterValue <= ZERO16;
    else if (cntWrite)
      counterValue <= cntWriteData;
    // A forced update reinitialises the counter even while update events are disabled.
    else if (forcedUpdate)
    begin
      if (centered || !ctrl.dirDown)
        counterValue <= ZERO16;
      else
        counterValue <= next_periodShadow;
    end
    else if (cntTick)
    begin
      if (ovf && !centered)
        counterValue <= ZERO16;
      else if (unf && !centered)
        counterValue <= next_periodShadow;
      else if (ovf)
        counterValue <= counterValue - 16'h0001;
      else if (unf)
        counterValue <= ZERO16;
      else if (ctrl.dirDown)
        counterValue <= counterValue - 16'h0001;
      else
        counterValue <= counterValue + 16'h0001;
    end
  end

  // The period shadow follows the preload directly unless preload is enabled.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      periodShadow <= PERIOD_RESET;
      presShadow   <= ZERO16;
    end
    else
    begin
      if (!ctrl.periodPreload || updateEv)
        periodShadow <= periodPreload;
      if (updateEv)
        presShadow <= presPreload;
    end
  end

  // Each overflow and underflow counts in center mode, halving the span.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      repeatCount <= REP_W'(REPEAT_RESET);
    else if (forcedUpdate)
      repeatCount <= repeatReg;
    else if (ovf || unf)
      repeatCount <= repZero ? repeatReg : repeatCount - 1'b1;
  end

  // ----------------------------------------------------------------
  // Status flag, interrupt and read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      updateFlag <= 1'b0;
    else if (setFlag)
      updateFlag <= 1'b1;
    else if (wrCycle && avs_byteenable[0] && avs_address == ADDR_STATUS && !avs_writedata[0])
      updateFlag <= 1'b0;
  end

  assign updateIrq = updateFlag & ctrl.updateIrqEn;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      events <= '0;
    else
      events <= '{overflow: ovf, underflow: unf, updateEvent: updateEv};
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      avs_readdata <= 32'h00000000;
    else if (rdCycle)
    begin
      case (avs_address)
        ADDR_CTRL:   avs_readdata <= {23'h000000, ctrl.updateIrqEn, ctrl.periodPreload, ctrl.centerAlign,
                                      ctrl.dirDown, 1'b0, ctrl.updateReqSource, ctrl.updateDisable, ctrl.run};
        ADDR_STATUS: avs_readdata <= {31'h00000000, updateFlag};
        ADDR_SLAVE:  avs_readdata <= {25'h0000000, slaveCtrl};
        ADDR_COUNT:  avs_readdata <= {16'h0000, counterValue};
        ADDR_PRESC:  avs_readdata <= {16'h0000, presPreload};
        ADDR_PERIOD: avs_readdata <= {16'h0000, periodPreload};
        ADDR_REPEAT: avs_readdata <= {{(32-REP_W){1'b0}}, repeatReg};
        default:     avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_enable_follows: assert property (@(posedge clk_sys) disable iff (sys_rst) countEnable == $past(ctrl.run))
    else $error("count enable does not follow run bit");
  a_update_disable_blocks: assert property (@(posedge clk_sys) disable iff (sys_rst) ctrl.updateDisable |-> !updateEv)
    else $error("update while disabled");
  a_force_update: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (forcedUpdate && !ctrl.updateDisable) |=> presCount == ZERO16 && repeatCount == $past(repeatReg))
    else $error("forced update did not restart");
  a_urs_noflag: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (swUpdate && ctrl.updateReqSource && !updateFlag && !ovf && !unf) |=> !updateFlag)
    else $error("flag set by generate bit with source select");
  a_flag_sets: assert property (@(posedge clk_sys) disable iff (sys_rst) setFlag |=> updateFlag)
    else $error("update flag not set");
  a_shadow_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
      updateEv |=> presShadow == $past(presPreload) && periodShadow == $past(periodPreload))
    else $error("shadows not reloaded");
  a_up_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (ovf && !centered && !cntWrite && !forcedUpdate) |=> counterValue == ZERO16)
    else $error("up count did not wrap");
  a_center_turn: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (centered && ovf && !cntWrite) |=> ctrl.dirDown)
    else $error("direction not turned at overflow");
  a_center_bottom: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (centered && unf && !cntWrite) |=> !ctrl.dirDown)
    else $error("direction not turned at underflow");
  a_down_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (unf && !centered && !cntWrite) |=> counterValue == periodShadow)
    else $error("down count did not reload the refreshed period");
  a_rep_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ((ovf || unf) && !repZero && !forcedUpdate) |-> !updateEv)
    else $error("update before repetition count reached zero");
  a_ps_restart: assert property (@(posedge clk_sys) disable iff (sys_rst)
      forcedUpdate |=> presCount == ZERO16)
    else $error("prescaler not restarted");
  a_ug_self_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
      swUpdate |=> !swUpdate)
    else $error("generate strobe longer than one cycle");
  a_flag_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (updateFlag && !(wrCycle && avs_address == ADDR_STATUS)) |=> updateFlag)
    else $error("update flag dropped without a clear");
  a_count_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!countEnable && !cntWrite && !forcedUpdate) |=> counterValue == $past(counterValue))
    else $error("counter moved while disabled");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (updateFlag && ctrl.updateIrqEn) |-> updateIrq)
    else $error("interrupt missing");

endmodule : atb_time_base

// ---- verif/atb_time_base_test.sv ----
// Self-checking bench for the timer time base: counting modes, updates, flag and repetition.
// Assumes the design's Avalon-MM slave answers with waitrequest and that events are one-cycle pulses.
module atb_time_base_test;
  timeunit 1ns;
  timeprecision 1ps;
  import atb_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk_sys             = 1'b0;
  logic        sys_rst             = 1'b1;
  logic [4:0]  avs_address         = 5'h00;
  logic        avs_read            = 1'b0;
  logic        avs_write           = 1'b0;
  logic [31:0] avs_writedata       = 32'h00000000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        timerInputTick      = 1'b0;
  logic        triggerUpdate       = 1'b0;
  logic        tickOn              = 1'b0;
  logic [1:0]  tickDiv             = 2'h0;
  atb_events_t events;
  logic        countEnable;
  logic [15:0] counterValue;
  logic        updateIrq;
  logic [31:0] rdata;
  int          err_count           = 0;
  int          n_checks            = 0;
  int          nOv                 = 0;
  int          nUn                 = 0;
  int          nUe                 = 0;
  int          gap;

  atb_time_base #(.REP_W(8)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timerInputTick(timerInputTick),
    .extTriggerTick(1'b0), .internalTriggerTick(1'b0), .triggerUpdate(triggerUpdate),
    .events(events), .countEnable(countEnable), .counterValue(counterValue), .updateIrq(updateIrq)
  );

  always #2 clk_sys = ~clk_sys;

  // Timer-input ticks every fourth cycle, so a source mix-up shows as a wrong period.
  always @(posedge clk_sys)
  begin
    tickDiv        <= tickDiv + 2'h1;
    timerInputTick <= tickOn & (tickDiv == 2'h3);
  end

  // Running tallies of event pulses; tests compare differences over a window.
  always @(negedge clk_sys)
  begin
    nOv <= nOv + ((events.overflow === 1'b1) ? 1 : 0);
    nUn <= nUn + ((events.underflow === 1'b1) ? 1 : 0);
    nUe <= nUe + ((events.updateEvent === 1'b1) ? 1 : 0);
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic fail_hang(input string what);
    err_count++;
    $display("wrong value at %0t: timeout waiting for %s", $time, what);
    report_and_stop();
  endtask : fail_hang

  // One Avalon transfer; request held until waitrequest is seen low, then released.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_sys);
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_address   <= a;
    avs_writedata <= d;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (i == 20)
      fail_hang("waitrequest");
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  function automatic logic pick(input int sel);
    return (sel == 0) ? events.overflow : (sel == 1) ? events.underflow : events.updateEvent;
  endfunction : pick

  // Counts cycles up to the next pulse of the chosen event.
  task automatic wait_ev(input int sel, output int n);
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (pick(sel) !== 1'b1 && n < 1500);
    if (n >= 1500)
      fail_hang("event pulse");
  endtask : wait_ev

  task automatic spacing(input int sel, output int n);
    wait_ev(sel, n);
    wait_ev(sel, n);
  endtask : spacing

  // Stop, program, force an update so shadows load, clear the flag, then apply the control word.
  task automatic setup(input logic [31:0] ctl, input logic [31:0] per, input logic [31:0] psc,
                       input logic [31:0] rep);
    wr(ADDR_CTRL, 32'h00000000);
    wr(ADDR_PERIOD, per);
    wr(ADDR_PRESC, psc);
    wr(ADDR_REPEAT, rep);
    wr(ADDR_COUNT, 32'h00000000);
    wr(ADDR_EVGEN, 32'h00000001);
    wr(ADDR_STATUS, 32'h00000000);
    wr(ADDR_CTRL, ctl);
  endtask : setup

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check(32'(counterValue), 32'h00000000);
    check(32'(countEnable), 32'h00000000);
    check(32'(updateIrq), 32'h00000000);
    bus(1'b0, ADDR_PERIOD, 32'h00000000, rdata);
    check(rdata, 32'(PERIOD_RESET));
    wr(5'h02, 32'h000000FF);
    bus(1'b0, 5'h02, 32'h00000000, rdata);
    check(rdata, 32'h00000000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_up();
    setup(32'h00000001, 32'h5, 32'h0, 32'h0);
    spacing(0, gap);
    check(32'(gap), 32'd6);
    check(32'(countEnable), 32'h00000001);
    spacing(2, gap);
    check(32'(gap), 32'd6);
    setup(32'h00000001, 32'h5, 32'h0, 32'h2);
    spacing(2, gap);
    check(32'(gap), 32'd18);
    setup(32'h00000001, 32'h5, 32'h2, 32'h0);
    spacing(0, gap);
    check(32'(gap), 32'd18);
    $display("test up done");
  endtask : t_up

  task automatic t_down();
    int ov0;
    setup(32'h00000011, 32'h5, 32'h0, 32'h0);
    ov0 = nOv;
    spacing(1, gap);
    check(32'(gap), 32'd6);
    check(32'(nOv - ov0), 32'd0);
    wr(ADDR_CTRL, 32'h00000010);
    wr(ADDR_COUNT, 32'h00000002);
    wr(ADDR_EVGEN, 32'h00000001);
    repeat (4) @(negedge clk_sys);
    check(32'(counterValue), 32'h00000005);
    $display("test down done");
  endtask : t_down

  task automatic t_center();
    int ov0;
    int un0;
    int ue0;
    logic [15:0] top;
    setup(32'h00000021, 32'h6, 32'h0, 32'h0);
    ov0 = nOv;
    un0 = nUn;
    ue0 = nUe;
    top = 16'h0000;
    repeat (120)
    begin
      @(negedge clk_sys);
      if (counterValue > top)
        top = counterValue;
    end
    check(32'(top), 32'h00000005);
    check(32'((nOv > ov0) && (nUn > un0)), 32'h00000001);
    check(32'(((nUe - ue0) - (nOv - ov0) - (nUn - un0)) inside {-1, 0, 1}), 32'h00000001);
    wr(ADDR_CTRL, 32'h00000020);
    repeat (4) @(negedge clk_sys);
    ue0 = nUe;
    wr(ADDR_COUNT, 32'h00000006);
    bus(1'b0, ADDR_CTRL, 32'h00000000, rdata);
    check(rdata & 32'h00000010, 32'h00000010);
    wr(ADDR_COUNT, 32'h00000000);
    bus(1'b0, ADDR_CTRL, 32'h00000000, rdata);
    check(rdata & 32'h00000010, 32'h00000000);
    wr(ADDR_COUNT, 32'h00000020);
    bus(1'b0, ADDR_CTRL, 32'h00000000, rdata);
    check(rdata & 32'h00000010, 32'h00000000);
    check(32'(nUe - ue0), 32'd0);
    wr(ADDR_EVGEN, 32'h00000001);
    bus(1'b0, ADDR_COUNT, 32'h00000000, rdata);
    check(rdata, 32'h00000000);
    $display("test center done");
  endtask : t_center

  task automatic t_update_disable();
    int ue0;
    int ov0;
    setup(32'h00000003, 32'h5, 32'h0, 32'h0);
    ue0 = nUe;
    ov0 = nOv;
    repeat (40) @(negedge clk_sys);
    check(32'(nUe - ue0), 32'd0);
    check(32'(nOv > ov0), 32'h00000001);
    $display("test update disable done");
  endtask : t_update_disable

  task automatic t_flag();
    int ue0;
    setup(32'h00000104, 32'h5, 32'h0, 32'h0);
    ue0 = nUe;
    wr(ADDR_EVGEN, 32'h00000001);
    repeat (6) @(negedge clk_sys);
    check(32'(nUe - ue0), 32'd1);
    bus(1'b0, ADDR_STATUS, 32'h00000000, rdata);
    check(rdata & 32'h00000001, 32'h00000000);
    check(32'(updateIrq), 32'h00000000);
    wr(ADDR_CTRL, 32'h00000100);
    wr(ADDR_EVGEN, 32'h00000001);
    repeat (6) @(negedge clk_sys);
    bus(1'b0, ADDR_STATUS, 32'h00000000, rdata);
    check(rdata & 32'h00000001, 32'h00000001);
    check(32'(updateIrq), 32'h00000001);
    wr(ADDR_STATUS, 32'h00000000);
    @(negedge clk_sys);
    check(32'(updateIrq), 32'h00000000);
    $display("test flag done");
  endtask : t_flag

  task automatic t_trig();
    int ue0;
    setup(32'h00000001, 32'h5, 32'h0, 32'h3);
    ue0 = nUe;
    @(posedge clk_sys);
    triggerUpdate <= 1'b1;
    @(posedge clk_sys);
    triggerUpdate <= 1'b0;
    repeat (4) @(negedge clk_sys);
    check(32'(nUe - ue0), 32'd1);
    wait_ev(2, gap);
    check(32'(gap > 16), 32'h00000001);
    $display("test trigger done");
  endtask : t_trig

  task automatic t_preload();
    setup(32'h00000081, 32'h5, 32'h0, 32'h0);
    wait_ev(0, gap);
    wr(ADDR_PERIOD, 32'h9);
    wait_ev(0, gap);
    check(32'(gap <= 6), 32'h00000001);
    wait_ev(0, gap);
    check(32'(gap), 32'd10);
    $display("test preload done");
  endtask : t_preload

  task automatic t_source();
    wr(ADDR_SLAVE, 32'h00000010);
    tickOn <= 1'b1;
    setup(32'h00000001, 32'h5, 32'h0, 32'h0);
    spacing(0, gap);
    check(32'(gap), 32'd24);
    wr(ADDR_SLAVE, 32'h00000000);
    spacing(0, gap);
    check(32'(gap), 32'd6);
    $display("test source done");
  endtask : t_source

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_up();
    t_down();
    t_center();
    t_update_disable();
    t_flag();
    t_trig();
    t_preload();
    t_source();
    report_and_stop();
  end
endmodule : atb_time_base_test
